//--- bench/frontend_control_registers_assertions.sv
// checker: port relations of the front-end control bank
`timescale 1ns/1ns
module frontend_control_registers_assertions
    import frontend_ctrl_pkg::*;
(
    // watched ports
    input wire logic clk_sys, rst, lpf4_power_down, lpf4_bypass, coarse_gain_amp_bypass,
    input wire logic tx_pll_clk_oe_n, rx_pll_clk_oe_n, pll_relock, adc_clk_from_rx_pll,
    input wire logic rx_port_clk_from_tx_pll, rx_sync_half_rate, lpf_wideband,
    input wire logic offset_corr_active,
    input wire logic [7:0] power_down,
    input wire logic [3:0] tx_pll_mult,
    input wire logic [2:0] rx_pll_mult, rx_pll_div,
    input wire logic [4:0] rx_gain
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_oe; {rx_pll_clk_oe_n, tx_pll_clk_oe_n} == power_down[6:5]; endproperty
    a_oe: assert property (p_oe) else $error("pll clock enable");
    property p_lpf; lpf4_power_down == lpf4_bypass; endproperty
    a_lpf: assert property (p_lpf) else $error("lpf power");
    property p_cga; coarse_gain_amp_bypass == power_down[0]; endproperty
    a_cga: assert property (p_cga) else $error("coarse bypass");
    property p_src; rx_port_clk_from_tx_pll != adc_clk_from_rx_pll; endproperty
    a_src: assert property (p_src) else $error("rx clock source");
    property p_sync; rx_sync_half_rate == adc_clk_from_rx_pll; endproperty
    a_sync: assert property (p_sync) else $error("rx sync rate");
    property p_l; $onehot(tx_pll_mult); endproperty
    a_l: assert property (p_l) else $error("tx multiplier");
    property p_mn; rx_pll_mult inside {3, 4, 6} && rx_pll_div inside {1, 2, 4}; endproperty
    a_mn: assert property (p_mn) else $error("rx pll ratio");
    property p_cap; lpf_wideband [*2] |-> rx_gain <= GAIN_WIDEBAND_CAP; endproperty
    a_cap: assert property (p_cap) else $error("gain cap");
    property p_rel; $rose(pll_relock) |-> pll_relock [*8]; endproperty
    a_rel: assert property (p_rel) else $error("relock short");
    property p_ofs; $rose(offset_corr_active) |-> offset_corr_active [*8]; endproperty
    a_ofs: assert property (p_ofs) else $error("offset short");
endmodule
bind frontend_control_registers frontend_control_registers_assertions chk_i (.*);

//--- bench/frontend_control_registers_tb_top.sv
// testbench: serial host drives the front-end control bank
`timescale 1ns/1ns
module frontend_control_registers_tb_top;
    import frontend_ctrl_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, power_select_pin = 1'b0, gain_strobe_pin = 1'b0;
    logic rx_port_nonmux = 1'b0, lsb = 1'b0, sclk, senable_n, sdata_in, sdata_out, sdata_oe_n;
    logic lpf4_power_down, lpf4_bypass, coarse_gain_amp_bypass, tx_pll_clk_oe_n, pll_relock;
    logic rx_pll_clk_oe_n, adc_clk_from_rx_pll, rx_port_clk_from_tx_pll, rx_clk_half_rate;
    logic rx_sync_half_rate, tx_capture_falling, one_pole_lpf_en, lpf_wideband, hpf_bypass;
    logic fast_adc_sampling, offset_corr_active, lpf_cal_active;
    logic [7:0] power_down, cutoff_target, rv;
    logic [4:0] tx_gain_pins = 5'h00, rx_gain;
    logic [3:0] tx_pll_mult;
    logic [2:0] rx_pll_mult, rx_pll_div;
    int bad_count = 0, num_checks = 0, n;
    always #20 clk_sys = ~clk_sys;
    frontend_control_registers #(.CAL_TIME(20), .CAL_PERIOD(4000)) uut (.*);
    host_serial_model host (.*);
    task automatic chk(input logic ok);
        num_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t mismatch", $time);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, lsb, rv);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, lsb, rv);
        chk(rv === e);
    endtask
    task automatic t_pd;
        wr(REG_POWER_DOWN_SET_PIN_LOW, 8'h21);
        wr(REG_POWER_DOWN_SET_PIN_HIGH, 8'h40);
        chk(power_down === 8'h21 && tx_pll_clk_oe_n === 1'b1);
        power_select_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(power_down === 8'h40 && rx_pll_clk_oe_n === 1'b1);
    endtask
    task automatic t_clk;
        logic [2:0] mv [4] = '{3'd3, 3'd4, 3'd6, 3'd3};
        logic [2:0] nv [4] = '{3'd2, 3'd4, 3'd1, 3'd2};
        for (int i = 0; i < 4; i++) begin
            wr(REG_CLOCK_SOURCE_CONFIG, {2'b11, 2'(i), 2'(i), 2'(i)});
            chk(tx_pll_mult === 4'(1 << i) && rx_pll_mult === mv[i] && rx_pll_div === nv[i]);
            chk(tx_capture_falling === 1'b1 && adc_clk_from_rx_pll === 1'b1);
        end
        wr(REG_CLOCK_SOURCE_CONFIG, RST_REG3);
        chk(rx_port_clk_from_tx_pll === 1'b1 && tx_capture_falling === 1'b0);
        rx_port_nonmux <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(rx_clk_half_rate === 1'b1);
    endtask
    task automatic t_gain;
        wr(REG_RECEIVE_GAIN_ADJUST, 8'h25);
        rd(REG_RECEIVE_GAIN_ADJUST, 8'h25);
        wr(REG_RECEIVE_FILTER_SELECT, 8'h1F);
        chk({hpf_bypass, one_pole_lpf_en, fast_adc_sampling} === 3'h7);
        wr(REG_RECEIVE_GAIN_ADJUST, 8'h35);
        rd(REG_RECEIVE_GAIN_ADJUST, 8'h32);
        wr(REG_RECEIVE_GAIN_ADJUST, 8'h00);
        tx_gain_pins <= 5'h0A;
        repeat (8) @(posedge clk_sys);
        gain_strobe_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(REG_RECEIVE_GAIN_ADJUST, 8'h0A);
    endtask
    task automatic t_ofs;
        wr(REG_RECEIVE_FILTER_SELECT, 8'h21);
        rd(REG_RECEIVE_FILTER_SELECT, 8'h21);
        for (n = 0; n < 400 && offset_corr_active; n++) @(posedge clk_sys);
        chk(n < 400);
        rd(REG_RECEIVE_FILTER_SELECT, 8'h01);
        wr(REG_RECEIVE_FILTER_SELECT, 8'hC1);
        for (n = 0; n < 4500 && !lpf_cal_active; n++) @(posedge clk_sys);
        chk(n == 4500);
    endtask
    task automatic t_srst;
        wr(REG_RESET_AND_SERIAL_CONFIG, 8'h40);
        lsb = 1'b1;
        wr(REG_POWER_DOWN_SET_PIN_LOW, 8'h55);
        rd(REG_POWER_DOWN_SET_PIN_LOW, 8'h55);
        wr(REG_RESET_AND_SERIAL_CONFIG, 8'h60);
        for (n = 0; n < 1000 && pll_relock; n++) @(posedge clk_sys);
        chk(n < 1000);
        rd(REG_RESET_AND_SERIAL_CONFIG, 8'h40);
        rd(REG_POWER_DOWN_SET_PIN_LOW, RST_REG1);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(REG_RESET_AND_SERIAL_CONFIG, RST_REG0);
        rd(REG_RECEIVE_GAIN_ADJUST, RST_REG6);
        chk(cutoff_target === RST_REG5 && sdata_oe_n === 1'b1);
        t_pd();
        t_clk();
        t_gain();
        t_ofs();
        t_srst();
        finish_test();
    end
endmodule

//--- bench/host_serial_model.sv
// partner: host driving the serial register port, one byte per frame
`timescale 1ns/1ns
module host_serial_model (
    // clock and serial pins
    input wire logic clk_sys,
    input wire logic sdata_out,
    output logic sclk = 1'b0,
    output logic senable_n = 1'b1,
    output logic sdata_in = 1'b0
);
    // single-byte frames, so each write lands alone at byte end
    task automatic xfer(input logic r, input logic [4:0] a, input logic [7:0] d,
        input logic lsb, output logic [7:0] q);
        logic [7:0] b;
        @(posedge clk_sys) senable_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            b = (i < 8) ? {r, 2'b00, a} : d;
            // while the device answers the line is not ours: keep it moving
            sdata_in <= (r && i > 7) ? ~sdata_in : b[lsb ? i % 8 : 7 - i % 8];
            repeat (6) @(posedge clk_sys);
            sclk <= 1'b1;
            q[lsb ? i % 8 : 7 - i % 8] = sdata_out;
            repeat (6) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
        senable_n <= 1'b1;
        sdata_in <= ~sdata_in;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

//--- core/frontend_control_registers.sv
// module: control register bank of the modem front end, registers 0 to 6
`timescale 1ns/1ns
module frontend_control_registers
    import frontend_ctrl_pkg::*;
#(
    parameter int CAL_TIME = CAL_CYCLES,
    parameter int CAL_PERIOD = CAL_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial register port
    input wire logic sclk,
    input wire logic senable_n,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe_n,
    // pins steering power, gain and the rx clock rate
    input wire logic power_select_pin,
    input wire logic gain_strobe_pin,
    input wire logic [4:0] tx_gain_pins,
    input wire logic rx_port_nonmux,
    // power-down controls
    output logic [7:0] power_down,
    output logic lpf4_power_down,
    output logic lpf4_bypass,
    output logic coarse_gain_amp_bypass,
    output logic tx_pll_clk_oe_n,
    output logic rx_pll_clk_oe_n,
    output logic pll_relock,
    // clock configuration
    output logic [3:0] tx_pll_mult,
    output logic [2:0] rx_pll_mult,
    output logic [2:0] rx_pll_div,
    output logic adc_clk_from_rx_pll,
    output logic rx_port_clk_from_tx_pll,
    output logic rx_clk_half_rate,
    output logic rx_sync_half_rate,
    output logic tx_capture_falling,
    // receive filter and gain
    output logic one_pole_lpf_en,
    output logic lpf_wideband,
    output logic fast_adc_sampling,
    output logic hpf_bypass,
    output logic offset_corr_active,
    output logic lpf_cal_active,
    output logic [7:0] cutoff_target,
    output logic [4:0] rx_gain
);
    import frontend_ctrl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] pwr_s;       // power-select synchroniser
        logic [2:0] strobe_s;    // gain strobe synchroniser
        logic [14:0] gain_s;     // gain pins, three stages of five
        logic pwr_q;             // filtered power-select level
        logic strobe_q;          // filtered strobe level
        logic [7:0] reg0;
        logic [7:0] reg1;
        logic [7:0] reg2;
        logic [7:0] reg3;
        logic [7:0] reg4;        // bits 5 and 6 live in the counters below
        logic [7:0] reg5;
        logic gain_by_reg;
        logic [4:0] gain_code;   // requested gain before the wideband cap
        logic [31:0] srst_cnt;   // soft reset and pll relock time
        logic [31:0] offs_cnt;   // offset correction time left
        logic [31:0] cal_cnt;    // calibration time left
        logic [31:0] per_cnt;    // time to next periodic calibration
        logic [2:0] nonmux_s;
        logic nonmux_q;
    } bank_state_t;

    bank_state_t s, next_s;
    reg_access_if ra ();

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // codes above the table top are held at the top
    function automatic logic [4:0] clamp_gain(input logic [4:0] code);
        clamp_gain = (code > GAIN_MAX) ? GAIN_MAX : code;
    endfunction

    // gain actually applied, limited in wideband mode
    function automatic logic [4:0] applied_gain(input logic [4:0] code, input logic wide);
        applied_gain = (wide && code > GAIN_WIDEBAND_CAP) ? GAIN_WIDEBAND_CAP : code;
    endfunction

    // ------------------------------------------------------------
    // serial port engine
    // ------------------------------------------------------------
    serial_reg_port u_port (
        .clk_sys(clk_sys),
        .rst(rst),
        .sclk(sclk),
        .senable_n(senable_n),
        .sdata_in(sdata_in),
        .sdata_out(sdata_out),
        .sdata_oe_n(sdata_oe_n),
        .ra(ra.port)
    );

    logic offs_run;
    logic cal_run;
    logic srst_run;
    logic [7:0] reg4_view;
    logic [7:0] reg6_view;
    logic [4:0] gain_now;

    assign offs_run = (s.offs_cnt != 32'h0);
    assign cal_run = (s.cal_cnt != 32'h0);
    assign srst_run = (s.srst_cnt != 32'h0);
    assign gain_now = applied_gain(s.gain_code, s.reg4[B4_WIDEBAND]);
    // status bits are overlaid on the stored control bits
    assign reg4_view = {s.reg4[7], cal_run, offs_run, s.reg4[4:0]};
    assign reg6_view = {2'b00, s.gain_by_reg, gain_now};

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // unmapped addresses read zero
    always_comb begin
        unique case (ra.addr)
            REG_RESET_AND_SERIAL_CONFIG: ra.rdata = {s.reg0[7:6], srst_run, s.reg0[4:0]};
            REG_POWER_DOWN_SET_PIN_LOW: ra.rdata = s.reg1;
            REG_POWER_DOWN_SET_PIN_HIGH: ra.rdata = s.reg2;
            REG_CLOCK_SOURCE_CONFIG: ra.rdata = s.reg3;
            REG_RECEIVE_FILTER_SELECT: ra.rdata = reg4_view;
            REG_FILTER_TUNING_TARGET: ra.rdata = s.reg5;
            REG_RECEIVE_GAIN_ADJUST: ra.rdata = reg6_view;
            default: ra.rdata = 8'h00;
        endcase
    end
    assign ra.lsb_first = s.reg0[B0_LSB_FIRST];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.pwr_s = {s.pwr_s[1:0], power_select_pin};
        next_s.strobe_s = {s.strobe_s[1:0], gain_strobe_pin};
        next_s.gain_s = {s.gain_s[9:0], tx_gain_pins};
        next_s.nonmux_s = {s.nonmux_s[1:0], rx_port_nonmux};
        // levels count once stages two and three agree
        if (s.pwr_s[2] == s.pwr_s[1]) begin
            next_s.pwr_q = s.pwr_s[2];
        end
        if (s.strobe_s[2] == s.strobe_s[1]) begin
            next_s.strobe_q = s.strobe_s[2];
        end
        if (s.nonmux_s[2] == s.nonmux_s[1]) begin
            next_s.nonmux_q = s.nonmux_s[2];
        end

        // timers run down
        if (srst_run) begin
            next_s.srst_cnt = s.srst_cnt - 32'h1;
        end
        if (offs_run) begin
            next_s.offs_cnt = s.offs_cnt - 32'h1;
        end
        if (cal_run) begin
            next_s.cal_cnt = s.cal_cnt - 32'h1;
        end

        // background calibration restarts at each period end
        if (!s.reg4[B4_CAL_DISABLE] && !cal_run) begin
            if (s.per_cnt <= 32'h1) begin
                next_s.cal_cnt = 32'(CAL_TIME);
                next_s.per_cnt = 32'(CAL_PERIOD);
            end else begin
                next_s.per_cnt = s.per_cnt - 32'h1;
            end
        end

        // gain strobe latches the pins in pin mode
        if (!s.gain_by_reg && s.strobe_s[2] == s.strobe_s[1] && s.strobe_s[2] && !s.strobe_q
            && s.gain_s[14:10] == s.gain_s[9:5]) begin
            next_s.gain_code = clamp_gain(s.gain_s[14:10]);
        end

        // register writes; a write that starts a timer beats the timer ending
        if (ra.wr_stb && !srst_run) begin
            unique case (ra.addr)
                REG_RESET_AND_SERIAL_CONFIG: begin
                    next_s.reg0 = ra.wdata;
                    next_s.reg0[B0_SOFT_RESET] = 1'b0;
                    if (ra.wdata[B0_SOFT_RESET]) begin
                        next_s.srst_cnt = 32'(RELOCK_CYCLES);
                    end
                end
                REG_POWER_DOWN_SET_PIN_LOW: next_s.reg1 = ra.wdata;
                REG_POWER_DOWN_SET_PIN_HIGH: next_s.reg2 = ra.wdata;
                REG_CLOCK_SOURCE_CONFIG: next_s.reg3 = ra.wdata;
                REG_RECEIVE_FILTER_SELECT: begin
                    // busy flags are not storage; a 1 written to bit 5 starts offset correction, bit 6 writes do nothing
                    next_s.reg4 = {ra.wdata[7], 2'b00, ra.wdata[4:0]};
                    if (ra.wdata[B4_OFFSET_CORR]) begin
                        next_s.offs_cnt = 32'(OFFSET_CYCLES);
                    end
                    if (!ra.wdata[B4_CAL_DISABLE]) begin
                        next_s.cal_cnt = 32'(CAL_TIME);
                        next_s.per_cnt = 32'(CAL_PERIOD);
                    end
                end
                REG_FILTER_TUNING_TARGET: next_s.reg5 = ra.wdata;
                REG_RECEIVE_GAIN_ADJUST: begin
                    next_s.gain_by_reg = ra.wdata[B6_GAIN_BY_REG];
                    if (ra.wdata[B6_GAIN_BY_REG]) begin
                        next_s.gain_code = clamp_gain(ra.wdata[4:0]);
                    end
                end
                default: begin
                end
            endcase
        end

        // end of soft reset: all defaults return but bit order stays
        if (s.srst_cnt == 32'h1) begin
            next_s.reg0 = RST_REG0;
            next_s.reg0[B0_LSB_FIRST] = s.reg0[B0_LSB_FIRST];
            next_s.reg1 = RST_REG1;
            next_s.reg2 = RST_REG2;
            next_s.reg3 = RST_REG3;
            next_s.reg4 = RST_REG4;
            next_s.reg5 = RST_REG5;
            next_s.gain_by_reg = RST_REG6[B6_GAIN_BY_REG];
            next_s.gain_code = RST_REG6[4:0];
            next_s.offs_cnt = 32'h0;
            next_s.cal_cnt = 32'(CAL_TIME);
            next_s.per_cnt = 32'(CAL_PERIOD);
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // the interpolator data path is not held here, so no reset reaches it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.reg0 <= RST_REG0;
            s.reg1 <= RST_REG1;
            s.reg2 <= RST_REG2;
            s.reg3 <= RST_REG3;
            s.reg4 <= RST_REG4;
            s.reg5 <= RST_REG5;
            s.gain_by_reg <= RST_REG6[B6_GAIN_BY_REG];
            s.gain_code <= RST_REG6[4:0];
            s.cal_cnt <= 32'(CAL_TIME);
            s.per_cnt <= 32'(CAL_PERIOD);
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // power-down outputs
    // ------------------------------------------------------------
    // the pin picks which set is in force
    assign power_down = s.pwr_q ? s.reg2 : s.reg1;
    assign coarse_gain_amp_bypass = power_down[PD_LPF_COARSE];
    assign lpf4_bypass = s.reg4[B4_LPF_BYPASS] || power_down[PD_LPF_COARSE];
    assign lpf4_power_down = lpf4_bypass;
    // a stopped pll lets its clock pin float
    assign tx_pll_clk_oe_n = power_down[PD_TX_PLL];
    assign rx_pll_clk_oe_n = power_down[PD_RX_PLL];
    assign pll_relock = srst_run;

    // ------------------------------------------------------------
    // clock configuration outputs
    // ------------------------------------------------------------
    assign tx_pll_mult = 4'h1 << s.reg3[B3_L_LO +: 2];
    // code 11 of the rx fields is not defined; it maps to the default factor
    always_comb begin
        unique case (s.reg3[B3_M_LO +: 2])
            2'h0: rx_pll_mult = 3'h3;
            2'h1: rx_pll_mult = 3'h4;
            2'h2: rx_pll_mult = 3'h6;
            default: rx_pll_mult = 3'h3;
        endcase
        unique case (s.reg3[B3_N_LO +: 2])
            2'h0: rx_pll_div = 3'h2;
            2'h1: rx_pll_div = 3'h4;
            2'h2: rx_pll_div = 3'h1;
            default: rx_pll_div = 3'h2;
        endcase
    end
    assign adc_clk_from_rx_pll = s.reg3[B3_ADC_SRC];
    assign rx_sync_half_rate = s.reg3[B3_ADC_SRC];
    // with the input clock as adc source the host keeps l and k at 4
    assign rx_port_clk_from_tx_pll = !s.reg3[B3_ADC_SRC];
    assign rx_clk_half_rate = s.nonmux_q;
    assign tx_capture_falling = s.reg3[B3_TX_FALL];

    // ------------------------------------------------------------
    // receive filter and gain outputs
    // ------------------------------------------------------------
    assign one_pole_lpf_en = s.reg4[B4_ONE_POLE];
    assign lpf_wideband = s.reg4[B4_WIDEBAND];
    assign fast_adc_sampling = s.reg4[B4_FAST_ADC];
    // above 50 msps the host must set this bypass
    assign hpf_bypass = s.reg4[B4_HPF_BYPASS];
    assign offset_corr_active = offs_run;
    assign lpf_cal_active = cal_run;
    assign cutoff_target = s.reg5;
    assign rx_gain = gain_now;

endmodule

//--- core/frontend_ctrl_pkg.sv
// package: register map, field positions, reset values and timing for the front-end control bank
package frontend_ctrl_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] REG_RESET_AND_SERIAL_CONFIG = 5'h00;
    localparam logic [4:0] REG_POWER_DOWN_SET_PIN_LOW = 5'h01;
    localparam logic [4:0] REG_POWER_DOWN_SET_PIN_HIGH = 5'h02;
    localparam logic [4:0] REG_CLOCK_SOURCE_CONFIG = 5'h03;
    localparam logic [4:0] REG_RECEIVE_FILTER_SELECT = 5'h04;
    localparam logic [4:0] REG_FILTER_TUNING_TARGET = 5'h05;
    localparam logic [4:0] REG_RECEIVE_GAIN_ADJUST = 5'h06;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG0 = 8'h00;
    localparam logic [7:0] RST_REG1 = 8'h00;
    localparam logic [7:0] RST_REG2 = 8'h9F;
    localparam logic [7:0] RST_REG3 = 8'h02;
    localparam logic [7:0] RST_REG4 = 8'h01;
    localparam logic [7:0] RST_REG5 = 8'h80;
    localparam logic [7:0] RST_REG6 = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B0_SOFT_RESET = 5;
    localparam int B0_LSB_FIRST = 6;
    localparam int PD_LPF_COARSE = 0;
    localparam int PD_TX_PLL = 5;
    localparam int PD_RX_PLL = 6;
    localparam int B3_L_LO = 0;
    localparam int B3_N_LO = 2;
    localparam int B3_M_LO = 4;
    localparam int B3_ADC_SRC = 6;
    localparam int B3_TX_FALL = 7;
    localparam int B4_LPF_BYPASS = 0;
    localparam int B4_ONE_POLE = 1;
    localparam int B4_WIDEBAND = 2;
    localparam int B4_FAST_ADC = 3;
    localparam int B4_HPF_BYPASS = 4;
    localparam int B4_OFFSET_CORR = 5;
    localparam int B4_CAL_BUSY = 6;
    localparam int B4_CAL_DISABLE = 7;
    localparam int B6_GAIN_BY_REG = 5;
    localparam logic [4:0] GAIN_MAX = 5'h15;
    localparam logic [4:0] GAIN_WIDEBAND_CAP = 5'h12;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 25000000;
    localparam longint CAL_TIME_MS = 500;
    localparam longint CAL_PERIOD_MS = 2000;
    localparam longint OFFSET_TIME_US = 10;
    localparam longint RELOCK_TIME_US = 20;
    localparam int CAL_CYCLES = int'(CAL_TIME_MS * CLK_HZ / 1000);
    localparam int CAL_PERIOD_CYCLES = int'(CAL_PERIOD_MS * CLK_HZ / 1000);
    localparam int OFFSET_CYCLES = int'(OFFSET_TIME_US * CLK_HZ / 1000000);
    localparam int RELOCK_CYCLES = int'(RELOCK_TIME_US * CLK_HZ / 1000000);

endpackage

//--- core/reg_access_if.sv
// interface: register access between the serial port engine and the register bank
`timescale 1ns/1ns
interface reg_access_if;
    logic wr_stb;        // one-cycle write of wdata to addr
    logic [4:0] addr;    // register address for write and read
    logic [7:0] wdata;   // byte assembled from the serial line
    logic [7:0] rdata;   // read value of addr
    logic lsb_first;     // current serial bit order

    modport port (output wr_stb, output addr, output wdata, input rdata, input lsb_first);
    modport bank (input wr_stb, input addr, input wdata, output rdata, output lsb_first);
endinterface

//--- core/serial_reg_port.sv
// module: serial register port engine, instruction then one to four data bytes
`timescale 1ns/1ns
module serial_reg_port
    import frontend_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial pins
    input wire logic sclk,
    input wire logic senable_n,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe_n,
    // register side
    reg_access_if.port ra
);
    import frontend_ctrl_pkg::*;

    typedef struct packed {
        logic [2:0] sclk_s;    // three-stage synchroniser
        logic [2:0] sen_s;
        logic [2:0] sd_s;
        logic sclk_q;          // filtered clock level
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic in_data;         // instruction byte done
        logic is_read;
        logic [1:0] bytes_left;
        logic [4:0] addr;
        logic [7:0] shift_out;
        logic fresh;           // new read byte already on the line
        logic done;            // all bytes moved, wait for deselect
        logic wr_stb;
        logic [7:0] wdata;
        logic adv;             // address step due
    } port_state_t;

    port_state_t s, next_s;
    logic rise;
    logic fall;
    logic sen_active;
    logic [7:0] byte_in;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // the clock level counts only once the second and third stages agree; enable is active only while both are low; data is taken from the third stage
    always_comb begin
        next_s = s;
        next_s.sclk_s = {s.sclk_s[1:0], sclk};
        next_s.sen_s = {s.sen_s[1:0], senable_n};
        next_s.sd_s = {s.sd_s[1:0], sdata_in};
        next_s.wr_stb = 1'b0;
        next_s.adv = 1'b0;
        if (s.adv) begin
            next_s.addr = ra.lsb_first ? s.addr + 5'h01 : s.addr - 5'h01;
        end
        rise = (s.sclk_s[2] == s.sclk_s[1]) && s.sclk_s[2] && !s.sclk_q;
        fall = (s.sclk_s[2] == s.sclk_s[1]) && !s.sclk_s[2] && s.sclk_q;
        sen_active = (s.sen_s[2] == s.sen_s[1]) ? !s.sen_s[2] : 1'b0;
        if (s.sclk_s[2] == s.sclk_s[1]) begin
            next_s.sclk_q = s.sclk_s[2];
        end
        // bit order follows the bank for instruction and data alike
        byte_in = ra.lsb_first ? {s.sd_s[2], s.shift_in[7:1]} : {s.shift_in[6:0], s.sd_s[2]};
        if (!sen_active) begin
            // deselect drops the transfer at once
            next_s.bit_cnt = 3'h0;
            next_s.in_data = 1'b0;
            next_s.done = 1'b0;
            next_s.is_read = 1'b0;
        end else if (rise && !s.done) begin
            next_s.shift_in = byte_in;
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
                if (!s.in_data) begin
                    // instruction: read flag, byte count, start address
                    next_s.in_data = 1'b1;
                    next_s.is_read = byte_in[7];
                    next_s.bytes_left = byte_in[6:5];
                    next_s.addr = byte_in[4:0];
                end else begin
                    // each byte lands as it completes, so a burst updates in sequence
                    next_s.wr_stb = !s.is_read;
                    next_s.wdata = byte_in;
                    next_s.adv = 1'b1;
                    next_s.bytes_left = s.bytes_left - 2'h1;
                    next_s.done = (s.bytes_left == 2'h0);
                end
            end
        end
        // read data is reloaded once the address has settled
        if (s.in_data && s.is_read && s.bit_cnt == 3'h0 && !s.done && !s.fresh
            && !rise && !s.sclk_q) begin
            next_s.shift_out = ra.rdata;
            next_s.fresh = 1'b1;
        end else if (fall && s.in_data && s.is_read && s.bit_cnt != 3'h0) begin
            if (s.fresh && s.bit_cnt == 3'h1) begin
                next_s.fresh = 1'b1;
            end
            next_s.shift_out = ra.lsb_first ? {1'b0, s.shift_out[7:1]} : {s.shift_out[6:0], 1'b0};
            if (s.bit_cnt == 3'h7) begin
                next_s.fresh = 1'b0;
            end
        end
        if (!s.in_data) begin
            next_s.fresh = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.sen_s <= 3'h7;
        end else begin
            s <= next_s;
        end
    end

    assign ra.wr_stb = s.wr_stb;
    assign ra.addr = s.addr;
    assign ra.wdata = s.wdata;
    assign sdata_out = ra.lsb_first ? s.shift_out[0] : s.shift_out[7];
    assign sdata_oe_n = !(s.in_data && s.is_read && !s.done);

endmodule
